// >>> rtl/sts_sequencer.sv
// sweep trigger sequencer: per-channel trigger modes, source select,
// point/sweep events and low-latency external trigger with delay.
// assumes an apb master on pclk and an asynchronous trigger pin.
`timescale 1ns/1ps
`include "sts_regs.svh"

// Function
// - each channel keeps its own trigger mode that decides its response
// - hold channels stay idle and never sweep on a trigger
// - single channels sweep once on next trigger then go idle
// - continuous channels stay armed and sweep on every trigger
// - one command sets every channel to hold
// - one command sets displayed channels to continuous, others unchanged
// - exactly one of four trigger sources is selected
// - internal source triggers continuously once selected
// - restart aborts a sweep in progress at once
// - point event: one measurement point per trigger
// - sweep event: all points measured per trigger
// - internal source ignores point event setting
// - low latency usable only with point event and external source
// - low latency applies external delay before each point
// - non-external source keeps low latency inactive
// - one low latency setting shared by all channels
// - external delay programmed in 10 us steps
// - external pulses during a point measurement are ignored
// - next point starts only from a pulse after the point completes
// - armed channels swept in ascending order, channel 0 to 15
// - index high before first point, low after last, in low latency
// - bus source triggers once per common trigger command
module sts_sequencer
  import sts_pkg::*;
#(
  parameter int NCH = 16
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output sts_apb_rsp_s     apb_rsp,
  // trigger pin
  input  wire logic        ext_trig,
  // sweep engine
  output sts_sweep_out_s   sweep_out
);

  // elaboration checks: the status word and mode word hold 16 channels
  if (NCH < 1 || NCH > 16) begin : g_nch_check
    $error("NCH must be 1 to 16");
  end

  // the delay divider needs at least one clock per step
  if (`STS_DLY_STEP_CYC < 1) begin : g_step_check
    $error("delay step must be at least one clock");
  end

  localparam logic [15:0] STEP_CYC = 16'(`STS_DLY_STEP_CYC);

  // register map, one aligned word each:
  //   CTRL   0x00  [1:0] source, [2] point event, [3] low latency
  //   MODE   0x04  two bits per channel: hold, single, continuous
  //   DISP   0x08  displayed channel mask
  //   CMD    0x0C  write-only pulses:
  //                [0] hold all, [1] continuous on displayed,
  //                [2] manual trigger, [3] bus trigger, [4] restart
  //   POINTS 0x10  points per sweep
  //   DELAY  0x14  external delay in steps of ten microseconds
  //   MEAS   0x18  clocks spent measuring one point
  //   STATUS 0x1C  read-only: [0] active, [3:1] state,
  //                [7:4] channel, [24:9] armed mask
  // writes to STATUS and to any unmapped offset are refused
  // with pslverr and change nothing.
  //
  // sequence of a trigger:
  //   idle     waits for a trigger, latches the armed mask
  //   scan     picks the lowest armed channel not yet swept
  //   delay    low latency only: waits the programmed delay
  //   meas     counts the point time, then strobes the point
  //   waittrig point event: holds until a fresh trigger
  // a restart command overrides every state and returns to idle.
  // the single-to-hold return wins over mode changes by command
  // when both land in the same clock.

  typedef struct packed {
    sts_apb_rsp_s   rsp;
    sts_sweep_out_s out;
    logic [1:0]     src;
    logic           point_on;
    logic           lowlat;
    logic [31:0]    modes;
    logic [15:0]    disp;
    logic [15:0]    npoints;
    logic [15:0]    delay;
    logic [15:0]    meas_cyc;
    logic [2:0]     sync;
    sts_state_e     state;
    logic [15:0]    armed;
    logic [4:0]     ch;
    logic [15:0]    pt;
    logic [15:0]    dly_cnt;
    logic [15:0]    step_cnt;
    logic [15:0]    meas_cnt;
  } sts_state_s;

  sts_state_s s_q;
  sts_state_s s_d;

  always_comb begin
    logic        wr;
    logic        rd;
    logic        trig;
    logic        ext_edge;
    logic        pt_mode;
    logic        ll_active;
    logic [4:0]  nx;
    logic        found;
    logic [31:0] rdata;
    wr        = 1'b0;
    rd        = 1'b0;
    trig      = 1'b0;
    ext_edge  = 1'b0;
    pt_mode   = 1'b0;
    ll_active = 1'b0;
    nx        = 5'h00;
    found     = 1'b0;
    rdata     = 32'h0000_0000;
    s_d       = s_q;

    s_d.rsp.pready   = 1'b0;
    s_d.rsp.pslverr  = 1'b0;
    s_d.out.meas_strobe = 1'b0;
    // two-stage synchroniser, third stage for the edge detect
    s_d.sync = {s_q.sync[1:0], ext_trig};
    ext_edge = s_q.sync[1] & ~s_q.sync[2];

    // one cycle access phase answer: the request is taken on the
    // first access edge and pready follows one clock later, so the
    // master always sees exactly one wait state
    if (psel && penable && !s_q.rsp.pready) begin
      s_d.rsp.pready = 1'b1;
      wr = pwrite;
      rd = !pwrite;
    end

    pt_mode   = s_q.point_on && (s_q.src != 2'(STS_SRC_INT));
    ll_active = pt_mode && s_q.lowlat
                && (s_q.src == 2'(STS_SRC_EXT));

    // exactly one source drives triggers
    case (sts_src_e'(s_q.src))
      STS_SRC_INT: begin
        trig = 1'b1;
      end
      STS_SRC_EXT: begin
        trig = ext_edge;
      end
      STS_SRC_MAN: begin
        trig = wr && paddr == `STS_OFF_CMD
               && pwdata[`STS_CMD_MANUAL];
      end
      STS_SRC_BUS: begin
        trig = wr && paddr == `STS_OFF_CMD
               && pwdata[`STS_CMD_BUS];
      end
      default: begin
        trig = 1'b0;
      end
    endcase

    if (wr) begin
      case (paddr)
        `STS_OFF_CTRL: begin
          s_d.src      = pwdata[`STS_CTRL_SRC_LSB +: 2];
          s_d.point_on = pwdata[`STS_CTRL_POINT_BIT];
          s_d.lowlat   = pwdata[`STS_CTRL_LOWLAT_BIT];
        end
        `STS_OFF_MODE: begin
          s_d.modes = pwdata;
        end
        `STS_OFF_DISP: begin
          s_d.disp = pwdata[15:0];
        end
        `STS_OFF_POINTS: begin
          s_d.npoints = pwdata[15:0];
        end
        `STS_OFF_DELAY: begin
          s_d.delay = pwdata[15:0];
        end
        `STS_OFF_MEAS: begin
          s_d.meas_cyc = pwdata[15:0];
        end
        `STS_OFF_CMD: begin
          if (pwdata[`STS_CMD_HOLD_ALL]) begin
            s_d.modes = 32'h0000_0000;
          end
          if (pwdata[`STS_CMD_CONT_DISP]) begin
            for (int i = 0; i < 16; i++) begin
              if (s_q.disp[i]) begin
                s_d.modes[2*i +: 2] = 2'(STS_MODE_CONT);
              end
            end
          end
        end
        `STS_OFF_STATUS: begin
          s_d.rsp.pslverr = 1'b1;
        end
        default: begin
          s_d.rsp.pslverr = 1'b1;
        end
      endcase
    end

    // read mux; command pulses read back as zero
    case (paddr)
      `STS_OFF_CTRL: begin
        rdata = {28'h0, s_q.lowlat, s_q.point_on, s_q.src};
      end
      `STS_OFF_MODE: begin
        rdata = s_q.modes;
      end
      `STS_OFF_DISP: begin
        rdata = {16'h0, s_q.disp};
      end
      `STS_OFF_POINTS: begin
        rdata = {16'h0, s_q.npoints};
      end
      `STS_OFF_DELAY: begin
        rdata = {16'h0, s_q.delay};
      end
      `STS_OFF_MEAS: begin
        rdata = {16'h0, s_q.meas_cyc};
      end
      `STS_OFF_CMD: begin
        rdata = 32'h0000_0000;
      end
      `STS_OFF_STATUS: begin
        // 7 spare + 16 armed + 1 spare + 4 channel + 3 state + 1 active
        rdata = {7'h00, s_q.armed, 1'b0, s_q.ch[3:0],
                 s_q.state, s_q.out.sweep_active};
      end
      default: begin
        rdata = 32'h0000_0000;
      end
    endcase
    if (rd) begin
      s_d.rsp.prdata = rdata;
      if (paddr > `STS_OFF_STATUS) begin
        s_d.rsp.pslverr = 1'b1;
      end
    end

    // next armed channel at or above ch, lowest first
    found = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (!found && i >= int'(s_q.ch) && i < NCH && s_q.armed[i]) begin
        nx    = 5'(i);
        found = 1'b1;
      end
    end

    case (s_q.state)
      STS_IDLE: begin
        s_d.out.sweep_active = 1'b0;
        if (trig) begin
          for (int i = 0; i < 16; i++) begin
            s_d.armed[i] = (i < NCH) &&
              (s_q.modes[2*i +: 2] == 2'(STS_MODE_SINGLE) ||
               s_q.modes[2*i +: 2] == 2'(STS_MODE_CONT));
          end
          s_d.ch    = 5'h00;
          s_d.state = STS_SCAN;
        end
      end
      STS_SCAN: begin
        if (!found) begin
          s_d.state = STS_IDLE;
          s_d.out.sweep_active = 1'b0;
        end else begin
          s_d.ch = nx;
          s_d.out.channel = nx[3:0];
          s_d.out.sweep_active = 1'b1;
          s_d.pt = 16'h0000;
          s_d.out.index = ll_active;
          s_d.dly_cnt  = s_q.delay;
          s_d.step_cnt = 16'h0000;
          s_d.state = ll_active ? STS_DELAY : STS_MEAS;
          s_d.meas_cnt = s_q.meas_cyc;
        end
      end
      STS_DELAY: begin
        // delay counted in steps of ten microseconds
        if (s_q.dly_cnt == 16'h0000) begin
          s_d.state = STS_MEAS;
          s_d.meas_cnt = s_q.meas_cyc;
        end else if (s_q.step_cnt == STEP_CYC - 16'h0001) begin
          s_d.step_cnt = 16'h0000;
          s_d.dly_cnt  = s_q.dly_cnt - 16'h0001;
        end else begin
          s_d.step_cnt = s_q.step_cnt + 16'h0001;
        end
      end
      STS_MEAS: begin
        // ext edges here fall through unused
        if (s_q.meas_cnt <= 16'h0001) begin
          s_d.out.meas_strobe = 1'b1;
          s_d.pt = s_q.pt + 16'h0001;
          if (s_q.pt + 16'h0001 >= s_q.npoints) begin
            // channel done; single channels return to hold
            if (s_q.modes[2*s_q.ch[3:0] +: 2] == 2'(STS_MODE_SINGLE)) begin
              s_d.modes[2*s_q.ch[3:0] +: 2] = 2'(STS_MODE_HOLD);
            end // continuous left as is
            s_d.armed[s_q.ch[3:0]] = 1'b0;
            s_d.out.index = 1'b0;
            s_d.state = pt_mode ? STS_WAITTRIG : STS_SCAN;
            if (pt_mode) begin
              s_d.pt = 16'hFFFF;
            end
          end else begin
            s_d.state = pt_mode ? STS_WAITTRIG : STS_MEAS;
            s_d.meas_cnt = s_q.meas_cyc;
          end
        end else begin
          s_d.meas_cnt = s_q.meas_cnt - 16'h0001;
        end
      end
      STS_WAITTRIG: begin
        // point mode: a fresh trigger after completion starts next point
        if (trig) begin
          if (s_q.pt == 16'hFFFF) begin
            s_d.state = STS_SCAN;
          end else begin
            s_d.dly_cnt  = s_q.delay;
            s_d.step_cnt = 16'h0000;
            s_d.meas_cnt = s_q.meas_cyc;
            s_d.state = ll_active ? STS_DELAY : STS_MEAS;
          end
        end
      end
      default: s_d.state = STS_IDLE;
    endcase

    if (wr && paddr == `STS_OFF_CMD && pwdata[`STS_CMD_RESTART]) begin
      s_d.state = STS_IDLE;
      s_d.armed = 16'h0000;
      s_d.out.sweep_active = 1'b0;
      s_d.out.index = 1'b0;
      s_d.out.meas_strobe = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.npoints  <= `STS_RST_POINTS;
      s_q.meas_cyc <= `STS_RST_MEAS;
      s_q.delay    <= `STS_RST_DELAY;
      s_q.state    <= STS_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_rsp   = s_q.rsp;
  assign sweep_out = s_q.out;

endmodule

// >>> rtl/sts_regs.svh
// register offsets, field positions, reset values and timing for the
// sweep trigger sequencer; assumes a 25 MHz apb clock
`ifndef STS_REGS_SVH
`define STS_REGS_SVH

`define STS_CLK_HZ          25000000
`define STS_DLY_STEP_NS     10000
`define STS_DLY_STEP_CYC    ((`STS_DLY_STEP_NS * 25) / 1000)

`define STS_OFF_CTRL        12'h000
`define STS_OFF_MODE        12'h004
`define STS_OFF_DISP        12'h008
`define STS_OFF_CMD         12'h00C
`define STS_OFF_POINTS      12'h010
`define STS_OFF_DELAY       12'h014
`define STS_OFF_MEAS        12'h018
`define STS_OFF_STATUS      12'h01C

`define STS_CTRL_SRC_LSB    0
`define STS_CTRL_POINT_BIT  2
`define STS_CTRL_LOWLAT_BIT 3

`define STS_CMD_HOLD_ALL    0
`define STS_CMD_CONT_DISP   1
`define STS_CMD_MANUAL      2
`define STS_CMD_BUS         3
`define STS_CMD_RESTART     4

`define STS_RST_POINTS      16'h0001
`define STS_RST_MEAS        16'h0004
`define STS_RST_DELAY       16'h0000

`endif

// >>> rtl/sts_pkg.sv
// types shared by the sweep trigger sequencer
package sts_pkg;
  typedef enum logic [1:0] {
    STS_MODE_HOLD, STS_MODE_SINGLE, STS_MODE_CONT, STS_MODE_RSVD
  } sts_mode_e;
  typedef enum logic [1:0] {
    STS_SRC_INT, STS_SRC_EXT, STS_SRC_MAN, STS_SRC_BUS
  } sts_src_e;
  typedef enum logic [2:0] {
    STS_IDLE, STS_SCAN, STS_DELAY, STS_MEAS, STS_WAITTRIG
  } sts_state_e;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sts_apb_rsp_s;
  typedef struct packed {
    logic        sweep_active;
    logic [3:0]  channel;
    logic        meas_strobe;
    logic        index;
  } sts_sweep_out_s;
endpackage

// >>> testbench/sts_trig_src.sv
// external trigger pulse source on the sequencer trigger pin
// assumes the bench asks for pulses just after a pclk edge
`timescale 1ns/1ps
module sts_trig_src (
  // clock and pin
  input  wire logic pclk,
  output logic      ext_trig
);
  initial ext_trig = 1'b0;
  // active-high pulse of w cycles, low between pulses
  task automatic pulse(input int w);
    ext_trig <= 1'b1;
    repeat (w) @(posedge pclk);
    ext_trig <= 1'b0;
  endtask
endmodule

// >>> testbench/sts_sequencer_monitor.sv
// port checker for the sweep trigger sequencer
// assumes one wait state on apb and registered sweep outputs
`timescale 1ns/1ps
module sts_sequencer_monitor
  import sts_pkg::*;
#(parameter int NCH = 16) (
  // clock and reset
  input wire logic           pclk,
  input wire logic           presetn,
  // apb
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [11:0]    paddr,
  input wire logic [31:0]    pwdata,
  input wire sts_apb_rsp_s   apb_rsp,
  // trigger and sweep
  input wire logic           ext_trig,
  input wire sts_sweep_out_s sweep_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rdy; psel && penable && !apb_rsp.pready |=> apb_rsp.pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready late");
  property p_one; apb_rsp.pready |=> !apb_rsp.pready; endproperty
  a_one: assert property (p_one) else $error("pready too long");
  property p_setup; psel && !penable |-> !apb_rsp.pready; endproperty
  a_setup: assert property (p_setup) else $error("pready in setup");
  property p_unmap; apb_rsp.pready && paddr > 12'h01C |-> apb_rsp.pslverr;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped not refused");
  property p_ro; apb_rsp.pready && pwrite && paddr == 12'h01C
    |-> apb_rsp.pslverr; endproperty
  a_ro: assert property (p_ro) else $error("status write not refused");
  property p_err; apb_rsp.pslverr |-> apb_rsp.pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_idx; sweep_out.index |-> sweep_out.sweep_active; endproperty
  a_idx: assert property (p_idx) else $error("index while idle");
  property p_order; sweep_out.sweep_active && $past(sweep_out.sweep_active)
    && $changed(sweep_out.channel)
    |-> sweep_out.channel > $past(sweep_out.channel); endproperty
  a_order: assert property (p_order) else $error("channel order");
  c_strobe: cover property (sweep_out.meas_strobe);
  c_index: cover property ($rose(sweep_out.index));
  c_err: cover property (apb_rsp.pslverr);
endmodule
bind sts_sequencer sts_sequencer_monitor #(.NCH(NCH)) mon_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .apb_rsp(apb_rsp), .ext_trig(ext_trig),
  .sweep_out(sweep_out));

// >>> testbench/sts_sequencer_tb.sv
// self-checking bench for the sweep trigger sequencer
// assumes the trigger source model and the port checker beside it
`timescale 1ns/1ps
`include "sts_regs.svh"
module sts_sequencer_tb
  import sts_pkg::*;
;
  logic           pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]    paddr = '0;
  logic [31:0]    pwdata = '0;
  sts_apb_rsp_s   apb_rsp;
  sts_sweep_out_s sweep_out;
  logic           ext_trig, idx_seen = 0;
  logic [64:0]    rq[$], x;
  logic [3:0]     chq[$];
  int             fail_count = 0, check_count = 0, cyc = 0, np, t0;
  sts_sequencer #(.NCH(16)) sts_sequencer_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .apb_rsp(apb_rsp), .ext_trig(ext_trig),
    .sweep_out(sweep_out));
  sts_trig_src sts_trig_src_i (.pclk(pclk), .ext_trig(ext_trig));
  initial forever #20 pclk = ~pclk;
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one apb transfer; the expected answer is queued for the watcher
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, e, m, logic r);
    rq.push_back({r, m, e});
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (apb_rsp.pready !== 1'b1) @(posedge pclk);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1, a, d, 0, 0, 0);
  endtask
  task automatic cmd(int b);
    wr(`STS_OFF_CMD, 32'h1 << b);
  endtask
  task automatic pts(int ch, int n);
    repeat (n) chq.push_back(4'(ch));
  endtask
  task automatic fin(string n);
    repeat (300) @(posedge pclk);
    check("pending points", chq.size(), 0);
    $display("test %s done", n);
  endtask
  task automatic ll_run(logic [31:0] c, logic ext, logic ll);
    wr(`STS_OFF_CTRL, c);
    idx_seen = 0;
    pts(1, 1);
    t0 = cyc;
    if (ext) sts_trig_src_i.pulse(2 + $urandom % 4);
    else cmd(`STS_CMD_MANUAL);
    while (sweep_out.meas_strobe !== 1'b1) @(posedge pclk);
    check("delayed", 32'(cyc - t0 >= `STS_DLY_STEP_CYC), 32'(ll));
    check("index", 32'(idx_seen), 32'(ll));
    fin("low latency");
  endtask
  // watcher: answers and completed points against the oldest notes
  always @(posedge pclk) begin
    if (apb_rsp.pready === 1'b1) begin
      x = rq.pop_front();
      check("prdata", apb_rsp.prdata & x[63:32], x[31:0]);
      check("pslverr", 32'(apb_rsp.pslverr), 32'(x[64]));
    end
    if (sweep_out.meas_strobe === 1'b1) begin
      if (chq.size() == 0) check("extra point", 1, 0);
      else check("channel", 32'(sweep_out.channel),
                 32'(chq.pop_front()));
    end
    if (sweep_out.index === 1'b1) idx_seen <= 1;
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(9557));
    np = 1 + $urandom % 3;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, `STS_OFF_POINTS, 0, `STS_RST_POINTS, 32'hFFFF, 0);
    apb(0, `STS_OFF_MEAS, 0, `STS_RST_MEAS, 32'hFFFF, 0);
    apb(0, `STS_OFF_DELAY, 0, `STS_RST_DELAY, 32'hFFFF, 0);
    apb(0, `STS_OFF_MODE, 0, 0, 32'hFFFF_FFFF, 0);
    apb(0, 12'h020, 0, 0, 0, 1);
    apb(1, `STS_OFF_STATUS, 0, 0, 0, 1);
    $display("test reset done");
    wr(`STS_OFF_CTRL, 32'h2);
    wr(`STS_OFF_POINTS, np);
    wr(`STS_OFF_MODE, 32'h21);
    pts(0, np);
    pts(2, np);
    cmd(`STS_CMD_MANUAL);
    fin("single and continuous");
    pts(2, np);
    cmd(`STS_CMD_MANUAL);
    fin("single back to idle");
    wr(`STS_OFF_CTRL, 32'h3);
    pts(2, np);
    cmd(`STS_CMD_BUS);
    fin("bus");
    cmd(`STS_CMD_HOLD_ALL);
    cmd(`STS_CMD_BUS);
    fin("hold all");
    wr(`STS_OFF_DISP, 32'h2);
    cmd(`STS_CMD_CONT_DISP);
    pts(1, np);
    cmd(`STS_CMD_BUS);
    fin("continuous displayed");
    wr(`STS_OFF_CTRL, 32'h5);
    pts(1, 1);
    sts_trig_src_i.pulse(3);
    fin("point");
    wr(`STS_OFF_MEAS, 32'hC8);
    pts(1, 1);
    sts_trig_src_i.pulse(3);
    repeat (20) @(posedge pclk);
    sts_trig_src_i.pulse(3);
    fin("early pulse");
    cmd(`STS_CMD_RESTART);
    wr(`STS_OFF_CTRL, 32'h2);
    cmd(`STS_CMD_MANUAL);
    repeat (20) @(posedge pclk);
    cmd(`STS_CMD_RESTART);
    apb(0, `STS_OFF_STATUS, 0, 0, 32'h1, 0);
    fin("restart");
    wr(`STS_OFF_MEAS, 32'h4);
    wr(`STS_OFF_DELAY, 32'h1);
    ll_run(32'hD, 1, 1);
    cmd(`STS_CMD_RESTART);
    ll_run(32'hE, 0, 0);
    cmd(`STS_CMD_RESTART);
    pts(3, np);
    wr(`STS_OFF_MODE, 32'h40);
    wr(`STS_OFF_CTRL, 32'h4);
    fin("internal");
    stop_test();
  end
endmodule
